// ---- rtl/hpp_host_port.v ----
// hpp_host_port.v: host access port, parallel byte bus or four-wire serial slave, onto 16-bit core registers.
// assumes all host pins are asynchronous to core_clk and strobes last several core_clk periods.
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "hpp_map.vh"
module hpp_host_port (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // parallel host bus
  input  wire        host_cs_n,
  input  wire        host_rd_n,
  input  wire        host_wr_n,
  input  wire        host_ale,
  input  wire        bus_style,
  input  wire [10:0] host_addr_bus,
  input  wire [7:0]  host_byte_bus_in,
  output reg  [7:0]  host_byte_bus_out,
  output reg         host_byte_bus_oe,
  // serial host port
  input  wire        serial_sel,
  input  wire        serial_clk,
  input  wire        serial_mosi,
  input  wire        serial_idle_level,
  input  wire        serial_sample_phase,
  input  wire        serial_lsb_first,
  output reg         serial_miso,
  output reg         serial_miso_oe,
  // open-drain interrupt
  output reg         irq_n_out,
  output reg         irq_n_oe,
  // core register side
  output reg  [9:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd,
  input  wire [15:0] reg_rdata,
  input  wire [7:0]  status_evt
);

  localparam ST_HDR  = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_DONE = 2'd2;

  // synchronised pins
  wire [10:0] ctl_s;
  wire [18:0] bus_s;

  hpp_sync #(.W(11), .RST_VAL(`HPP_CTL_SYNC_RST)) u_sync_ctl (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({host_cs_n, host_rd_n, host_wr_n, host_ale, bus_style, serial_sel, serial_clk,
                serial_mosi, serial_idle_level, serial_sample_phase, serial_lsb_first}),
    .q        (ctl_s)
  );

  hpp_sync #(.W(19), .RST_VAL(19'h00000)) u_sync_bus (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({host_addr_bus, host_byte_bus_in}),
    .q        (bus_s)
  );

  wire        cs_s    = ctl_s[10];
  wire        rd_s    = ctl_s[9];
  wire        wr_s    = ctl_s[8];
  wire        ale_s   = ctl_s[7];
  wire        style_s = ctl_s[6];
  wire        sel_s   = ctl_s[5];
  wire        sclk_s  = ctl_s[4];
  wire        mosi_s  = ctl_s[3];
  wire        cpol_s  = ctl_s[2];
  wire        cpha_s  = ctl_s[1];
  wire        lsbf_s  = ctl_s[0];
  wire [10:0] addr_s  = bus_s[18:8];
  wire [7:0]  data_s  = bus_s[7:0];

  // in data strobe style the read pin carries latch_pulse_n and the write pin the direction
  wire        latch_pulse_n = rd_s;

  // previous samples for edge detection
  reg rd_q;
  reg wr_q;
  reg ale_q;
  reg sclk_q;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q   <= 1'b1;
      wr_q   <= 1'b1;
      ale_q  <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      rd_q   <= rd_s;
      wr_q   <= wr_s;
      ale_q  <= ale_s;
      sclk_q <= sclk_s;
    end
  end

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        rev8[i] = v[7-i];
    end
  endfunction

  function [13:0] rev14;
    input [13:0] v;
    integer i;
    begin
      for (i = 0; i < 14; i = i + 1)
        rev14[i] = v[13-i];
    end
  endfunction

  // parallel bus decode
  wire par_en   = ~sel_s & ~cs_s;
  wire rd_fall  = rd_q & ~rd_s;
  wire rd_rise  = ~rd_q & rd_s;
  wire wr_rise  = ~wr_q & wr_s;
  wire ale_fall = ale_q & ~ale_s;

  // writes take data at the trailing strobe edge, when the host data is surely settled
  wire p_rd_go = par_en & (style_s ? (~latch_pulse_n & latch_pulse_n == 1'b0 & rd_fall & wr_s)
                                   : rd_fall);
  wire p_wr_go = par_en & (style_s ? (rd_rise & ~wr_s)
                                   : wr_rise);

  reg [10:0] addr_lat;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      addr_lat <= 11'h000;
    else if (ale_fall)
      addr_lat <= addr_s;
  end

  // a board with ale tied high uses the live address; a low ale holds the captured one
  wire [10:0] p_addr = ale_s ? addr_s : addr_lat;

  // serial engine state
  reg [1:0]  s_state;
  reg [3:0]  s_cnt;
  reg [15:0] s_shift;
  reg        s_rw;
  reg        s_burst;
  reg [10:0] s_addr;
  reg [10:0] s_req_addr;
  reg [7:0]  s_wbyte;
  reg        s_rd_req;
  reg        s_wr_req;
  reg [7:0]  s_tx;

  wire s_act      = sel_s & ~cs_s;
  wire samp_rise  = (cpol_s == cpha_s);
  wire sclk_rise  = ~sclk_q & sclk_s;
  wire sclk_fall  = sclk_q & ~sclk_s;
  wire s_samp     = s_act & (samp_rise ? sclk_rise : sclk_fall);
  wire s_launch   = s_act & (samp_rise ? sclk_fall : sclk_rise);
  wire [15:0] hdr = {s_shift[14:0], mosi_s};
  wire [13:0] hdr_field = lsbf_s ? rev14(hdr[14:1]) : hdr[14:1];
  wire [7:0]  rx_byte   = lsbf_s ? rev8(hdr[7:0]) : hdr[7:0];

  // shared byte access engine
  wire        acc_rd    = p_rd_go | s_rd_req;
  wire        acc_wr    = p_wr_go | s_wr_req;
  wire [10:0] acc_addr  = sel_s ? s_req_addr : p_addr;
  wire [7:0]  acc_wdata = sel_s ? s_wbyte : data_s;
  wire [9:0]  acc_word  = acc_addr[10:1];
  wire        is_ctrl   = (acc_word == `HPP_CTRL_WORD);
  wire        is_stat   = (acc_word == `HPP_STAT_WORD);

  reg [15:0] ctrl;
  reg [7:0]  status;
  reg [7:0]  wlat;
  reg        rd_issue;
  reg        rd_pend;
  reg        rd_hi;
  reg        rd_loc;
  reg [15:0] loc_q;

  wire [7:0]  stat_clr    = (acc_rd & is_stat & ~acc_addr[0]) ? status : 8'h00;
  wire [7:0]  next_status = (status & ~stat_clr) | status_evt;
  wire [15:0] rd_src      = rd_loc ? loc_q : reg_rdata;
  wire [7:0]  rd_byte     = rd_hi ? rd_src[15:8] : rd_src[7:0];
  wire        pending     = |(status & ctrl[`HPP_CTRL_MASK_MSB:`HPP_CTRL_MASK_LSB]);

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl      <= `HPP_CTRL_RST;
      status    <= `HPP_STAT_RST;
      wlat      <= 8'h00;
      rd_issue  <= 1'b0;
      rd_pend   <= 1'b0;
      rd_hi     <= 1'b0;
      rd_loc    <= 1'b0;
      loc_q     <= 16'h0000;
      reg_addr  <= 10'h000;
      reg_wdata <= 16'h0000;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
    end else begin
      status  <= next_status;
      reg_wr  <= 1'b0;
      reg_rd  <= 1'b0;
      rd_issue <= acc_rd;
      rd_pend  <= rd_issue;                                             // core data stands only after reg_rd
      if (acc_rd) begin
        reg_addr <= acc_word;
        reg_rd   <= ~(is_ctrl | is_stat);
        rd_hi    <= acc_addr[0];
        rd_loc   <= is_ctrl | is_stat;
        loc_q    <= is_ctrl ? ctrl : {8'h00, status};
      end else if (acc_wr) begin
        // low byte waits in a latch; the high byte commits the whole word
        if (!acc_addr[0]) begin
          wlat <= acc_wdata;
        end else if (is_ctrl) begin
          ctrl <= {acc_wdata, wlat} & `HPP_CTRL_WMASK;
        end else if (!is_stat) begin
          reg_addr  <= acc_word;
          reg_wdata <= {acc_wdata, wlat};
          reg_wr    <= 1'b1;
        end
      end
    end
  end

  // interrupt pin: low while pending, idle level by irq_idle_drive
  wire irq_idle_drive = ctrl[`HPP_CTRL_IDLE_BIT];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_out <= 1'b1;
      irq_n_oe  <= 1'b0;
    end else begin
      irq_n_out <= ~pending;
      irq_n_oe  <= pending | irq_idle_drive;
    end
  end

  // parallel read data: held on the bus until the strobe or select goes away
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_byte_bus_out <= 8'h00;
      host_byte_bus_oe  <= 1'b0;
    end else if (!par_en || rd_s) begin
      host_byte_bus_oe <= 1'b0;
    end else if (rd_pend) begin
      host_byte_bus_out <= rd_byte;
      host_byte_bus_oe  <= 1'b1;
    end
  end

  // serial slave: 16 header bits, then data bytes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_state    <= ST_HDR;
      s_cnt      <= 4'h0;
      s_shift    <= 16'h0000;
      s_rw       <= 1'b0;
      s_burst    <= 1'b0;
      s_addr     <= 11'h000;
      s_req_addr <= 11'h000;
      s_wbyte    <= 8'h00;
      s_rd_req   <= 1'b0;
      s_wr_req   <= 1'b0;
    end else begin
      s_rd_req <= 1'b0;
      s_wr_req <= 1'b0;
      if (!s_act) begin
        s_state <= ST_HDR;
        s_cnt   <= 4'h0;
      end else if (s_samp) begin
        s_shift <= hdr;
        case (s_state)
          ST_HDR: begin
            s_cnt <= s_cnt + 4'h1;
            if (s_cnt == `HPP_HDR_LAST) begin
              s_rw       <= hdr[15];
              s_burst    <= hdr[0];
              s_addr     <= hdr_field[10:0];
              s_req_addr <= hdr_field[10:0];
              s_rd_req   <= hdr[15];
              s_cnt      <= 4'h0;
              s_state    <= ST_DATA;
            end
          end
          ST_DATA: begin
            s_cnt <= s_cnt + 4'h1;
            if (s_cnt == `HPP_DATA_LAST) begin
              s_cnt <= 4'h0;
              if (!s_rw) begin
                s_wr_req   <= 1'b1;
                s_wbyte    <= rx_byte;
                s_req_addr <= s_addr;
              end
              if (s_burst) begin
                s_addr <= s_addr + 11'h001;
                if (s_rw) begin
                  s_rd_req   <= 1'b1;
                  s_req_addr <= s_addr + 11'h001;
                end
              end else begin
                s_state <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            s_cnt <= 4'h0;
          end
          default: begin
            s_state <= ST_HDR;
          end
        endcase
      end
    end
  end

  // serial output: full duplex, one bit out per launch edge while in a data byte
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_tx           <= 8'h00;
      serial_miso    <= 1'b0;
      serial_miso_oe <= 1'b0;
    end else begin
      serial_miso_oe <= s_act;
      if (!s_act) begin
        s_tx        <= 8'h00;
        serial_miso <= 1'b0;
      end else if (rd_pend) begin
        s_tx <= lsbf_s ? rev8(rd_byte) : rd_byte;
      end else if (s_launch && s_state == ST_DATA) begin
        serial_miso <= s_tx[7];
        s_tx        <= {s_tx[6:0], 1'b0};
      end
    end
  end

endmodule // hpp_host_port

// ---- rtl/hpp_map.vh ----
// hpp_map.vh: address map, field positions, reset values and serial framing constants for the host port.
// assumes it is included by bare name from the host port design files.
`ifndef HPP_MAP_VH
`define HPP_MAP_VH

// word addresses (host byte address / 2) of the port's own registers
`define HPP_CTRL_WORD       10'h3FE
`define HPP_STAT_WORD       10'h3FF

// control register fields
`define HPP_CTRL_IDLE_BIT   0
`define HPP_CTRL_MASK_MSB   15
`define HPP_CTRL_MASK_LSB   8
`define HPP_CTRL_WMASK      16'hFF01
`define HPP_CTRL_RST        16'h0000

// status register: latched events in the low byte
`define HPP_STAT_RST        8'h00

// serial framing
`define HPP_HDR_LAST        4'hF
`define HPP_DATA_LAST       4'h7

// serial clock ceiling the host must respect, and the core rate
`define HPP_CORE_HZ         25000000
`define HPP_SERIAL_MAX_HZ   10000000

// reset value of the synchronised control pins (cs, rd, wr, ale high)
`define HPP_CTL_SYNC_RST    11'h780
`endif

// ---- rtl/hpp_sync.v ----
// hpp_sync.v: two-flop synchroniser for a group of pins from outside the core_clk domain.
// assumes the group is sampled only through q; the first stage feeds nothing else.
`timescale 1ns/1ps
module hpp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         rst_n,
  // pins in, synchronised out
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule // hpp_sync

// ---- verif/hpp_checker.sv ----
// hpp_checker.sv: port-level assertions for the host port.
// assumes it is bound into hpp_host_port and sees only that module's ports.
`timescale 1ns/1ps
module hpp_checker (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // observed pins
  input wire host_cs_n,
  input wire serial_sel,
  input wire host_byte_bus_oe,
  input wire serial_miso_oe,
  input wire irq_n_out,
  input wire irq_n_oe,
  input wire reg_rd,
  input wire reg_wr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_float: assert property (disable iff (1'b0) !rst_n |-> !host_byte_bus_oe && !serial_miso_oe && !irq_n_oe)
    else $error("host outputs driven during reset");
  a_irq_open_drain: assert property (!irq_n_out |-> irq_n_oe)
    else $error("interrupt level low while not driven");
  a_irq_idle_float: assert property (!irq_n_oe |-> irq_n_out)
    else $error("interrupt released while pending");
  a_rd_single: assert property (reg_rd |=> !reg_rd)
    else $error("read pulse longer than one cycle");
  a_wr_single: assert property (reg_wr |=> !reg_wr)
    else $error("write pulse longer than one cycle");
  a_rd_wr_excl: assert property (!(reg_rd && reg_wr))
    else $error("read and write issued together");
  a_cs_ignored: assert property (host_cs_n [*6] |-> !reg_rd && !reg_wr)
    else $error("access issued while deselected");
  a_serial_quiet: assert property (host_cs_n [*4] |-> !serial_miso_oe)
    else $error("serial output driven while deselected");
  a_par_off: assert property (serial_sel [*4] |-> !host_byte_bus_oe)
    else $error("parallel bus driven in serial mode");
  a_read_answer: assert property (reg_rd && !serial_sel |-> ##[1:2] host_byte_bus_oe)
    else $error("parallel read not answered");
  c_read: cover property (reg_rd);
  c_write: cover property (reg_wr);
  c_irq: cover property (!irq_n_out);
endmodule // hpp_checker

bind hpp_host_port hpp_checker hpp_checker_i (.core_clk, .rst_n, .host_cs_n, .serial_sel, .host_byte_bus_oe,
  .serial_miso_oe, .irq_n_out, .irq_n_oe, .reg_rd, .reg_wr);

// ---- verif/hpp_core_regs.sv ----
// hpp_core_regs.sv: core register file standing behind the host port.
// assumes reg_rd and reg_wr are one-cycle pulses in the core_clk domain.
`timescale 1ns/1ps
module hpp_core_regs (
  // clock
  input  wire         core_clk,
  // register side
  input  wire  [9:0]  reg_addr,
  input  wire  [15:0] reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output logic [15:0] reg_rdata
);
  logic [15:0] mem [0:1023];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = {i[7:0], ~i[9:2]};
    end
    reg_rdata = 16'h0000;
  end
  always @(posedge core_clk) begin
    if (reg_wr) begin
      mem[reg_addr] <= reg_wdata;
    end
    // data is valid only in the cycle after the read; scrambled otherwise
    reg_rdata <= reg_rd ? mem[reg_addr] : ~reg_rdata;
  end
endmodule // hpp_core_regs

// ---- verif/hpp_host_port_tb.sv ----
// hpp_host_port_tb.sv: self-checking bench for the host port, parallel and serial.
// assumes hpp_core_regs models the core registers and hpp_checker is bound in.
`timescale 1ns/1ps
module hpp_host_port_tb;
  logic        core_clk, rst_n, host_cs_n, host_rd_n, host_wr_n, host_ale, bus_style, serial_sel, serial_clk;
  logic        serial_mosi, serial_idle_level, serial_sample_phase, serial_lsb_first;
  logic        host_byte_bus_oe, serial_miso, serial_miso_oe, irq_n_out, irq_n_oe, reg_wr, reg_rd;
  logic [10:0] host_addr_bus;
  logic [7:0]  host_byte_bus_in, host_byte_bus_out, status_evt, evt_mid, b, b2;
  logic [15:0] reg_wdata, reg_rdata, w, q;
  logic [9:0]  reg_addr, wd;
  logic [15:0] mdl [0:1023];
  integer      fail_count = 0;
  integer      compares = 0;

  hpp_host_port hpp_host_port_i (.core_clk, .rst_n, .host_cs_n, .host_rd_n, .host_wr_n, .host_ale, .bus_style,
    .host_addr_bus, .host_byte_bus_in, .host_byte_bus_out, .host_byte_bus_oe, .serial_sel, .serial_clk,
    .serial_mosi, .serial_idle_level, .serial_sample_phase, .serial_lsb_first, .serial_miso, .serial_miso_oe,
    .irq_n_out, .irq_n_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .status_evt);
  hpp_core_regs hpp_core_regs_i (.core_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] rv8(input logic [7:0] v);
    return {<<{v}};
  endfunction

  // one parallel byte access; cs_val 1 strobes with the port deselected
  task automatic pacc(input logic wr, input logic [10:0] a, input logic [7:0] d, input logic cs_val,
                      input logic mux, output logic [7:0] rd);
    host_addr_bus <= a;
    host_byte_bus_in <= d;
    host_cs_n <= cs_val;
    host_wr_n <= bus_style ? !wr : 1'b1;
    host_ale <= 1'b1;
    cyc(1);
    if (mux) begin
      host_ale <= 1'b0;
      cyc(1);
      host_addr_bus[7:0] <= d;
    end
    if (!bus_style && wr) begin
      host_wr_n <= 1'b0;
    end else begin
      host_rd_n <= 1'b0;
    end
    cyc(5);
    status_evt <= evt_mid;
    cyc(1);
    status_evt <= 8'h00;
    cyc(2);
    rd = host_byte_bus_out;
    if (!wr && !cs_val) begin
      chk(host_byte_bus_oe, 1'b1);
    end
    host_rd_n <= 1'b1;
    if (!bus_style) begin
      host_wr_n <= 1'b1;
    end
    cyc(2);
    host_wr_n <= 1'b1;
    host_cs_n <= 1'b1;
    // address latch stays low until the issued access has landed
    cyc(3);
    host_ale <= 1'b1;
    cyc(3);
    chk(host_byte_bus_oe, 1'b0);
  endtask

  // serial burst of two data bytes after the two header bytes
  task automatic sacc(input logic dir, input logic [10:0] a, input logic [15:0] d, output logic [15:0] r);
    logic [31:0] s;
    logic [31:0] c;
    logic [13:0] f;
    f = {3'b000, a};
    if (serial_lsb_first) begin
      f = {<<{f}};
      d = {rv8(d[15:8]), rv8(d[7:0])};
    end
    s = {dir, f, 1'b1, d[7:0], d[15:8]};
    host_cs_n <= 1'b0;
    cyc(4);
    chk(serial_miso_oe, 1'b1);
    for (int i = 31; i >= 0; i--) begin
      if (serial_sample_phase) begin
        serial_clk <= !serial_idle_level;
      end
      serial_mosi <= s[i];
      cyc(4);
      serial_clk <= serial_sample_phase ? serial_idle_level : !serial_idle_level;
      cyc(2);
      c[i] = serial_miso;
      cyc(2);
      if (!serial_sample_phase) begin
        serial_clk <= serial_idle_level;
      end
    end
    cyc(4);
    host_cs_n <= 1'b1;
    serial_mosi <= ~serial_mosi;
    cyc(6);
    chk(serial_miso_oe, 1'b0);
    r = serial_lsb_first ? {rv8(c[7:0]), rv8(c[15:8])} : {c[7:0], c[15:8]};
  endtask

  initial begin
    void'($urandom(32'hAAAC4A34));
    for (int i = 0; i < 1024; i++) begin
      mdl[i] = {i[7:0], ~i[9:2]};
    end
    {rst_n, host_cs_n, host_rd_n, host_wr_n, host_ale, bus_style, serial_sel} = 7'h3E;
    {serial_clk, serial_mosi, serial_idle_level, serial_sample_phase, serial_lsb_first} = 5'h00;
    {host_addr_bus, host_byte_bus_in, status_evt, evt_mid} = 35'h0;
    cyc(10);
    chk({host_byte_bus_oe, serial_miso_oe, irq_n_oe}, 3'h0);
    cyc(6);
    rst_n <= 1'b1;
    cyc(4);
    status_evt <= 8'h01;
    cyc(1);
    status_evt <= 8'h00;
    cyc(4);
    chk(irq_n_oe, 1'b0);
    pacc(1, 11'h7FC, 8'h00, 0, 0, b);
    pacc(1, 11'h7FD, 8'h01, 0, 0, b);
    chk({irq_n_oe, irq_n_out}, 2'b10);
    evt_mid = 8'h02;
    pacc(0, 11'h7FE, 8'h00, 0, 0, b);
    evt_mid = 8'h00;
    pacc(0, 11'h7FE, 8'h00, 0, 0, b2);
    chk({b[0], b2[0]}, 2'b10);
    chk((b | b2) & 8'h02, 8'h02);
    chk(irq_n_oe, 1'b0);
    pacc(1, 11'h7FC, 8'h01, 0, 0, b);
    pacc(1, 11'h7FD, 8'h01, 0, 0, b);
    chk({irq_n_oe, irq_n_out}, 2'b11);
    pacc(0, 11'h7FD, 8'h00, 0, 0, b);
    chk(b, 8'h01);
    for (int k = 0; k < 4; k++) begin
      bus_style <= k[0];
      cyc(2);
      wd = 10'($urandom_range(0, 1021));
      w = 16'($urandom);
      pacc(1, {wd, 1'b0}, w[7:0], 0, k[1], b);
      pacc(1, {wd, 1'b1}, w[15:8], 0, k[1], b);
      mdl[wd] = w;
      chk({reg_addr, reg_wdata}, {wd, w});
      pacc(1, {wd, 1'b1}, ~w[15:8], 1, k[1], b);
      pacc(0, {wd, 1'b0}, ~w[7:0], 0, k[1], b);
      chk(b, mdl[wd][7:0]);
      pacc(0, {wd, 1'b1}, ~w[7:0], 0, k[1], b);
      chk(b, mdl[wd][15:8]);
    end
    serial_sel <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      {serial_idle_level, serial_sample_phase} <= m[1:0];
      serial_lsb_first <= 1'($urandom);
      serial_clk <= m[1];
      cyc(4);
      wd = 10'($urandom_range(0, 1021));
      w = 16'($urandom);
      sacc(0, {wd, 1'b0}, w, q);
      mdl[wd] = w;
      chk({reg_addr, reg_wdata}, {wd, w});
      sacc(1, {wd, 1'b0}, ~w, q);
      chk(q, mdl[wd]);
    end
    conclude;
  end

  initial begin
    cyc(30000);
    fail_count++;
    conclude;
  end
endmodule // hpp_host_port_tb
